//--- design/pcl_write_lock.sv
/*
 * Command write-lock checker. Holds the 16-bit extended command lock
 * field, decides for every command write whether it may reach command
 * storage, and answers reads of the lock field.
 * Assumes the command interface, the write-protect storage, the unlock
 * key logic and the non-volatile store all run on ref_clk.
 */
`timescale 1ns/1ns
`include "pcl_cfg.svh"

module pcl_write_lock
    import pcl_pkg::*;
#(
    parameter int CMD_W = 8,
    parameter int DATA_W = 16
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_valid,
    input wire logic [CMD_W-1:0] wr_code,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_valid,
    input wire logic [CMD_W-1:0] rd_code,
    input wire logic [7:0] std_wp_level,
    input wire logic key_locked,
    input wire logic nvm_load,
    input wire logic [15:0] nvm_value,
    input wire logic nvm_store,
    output logic wr_grant_q,
    output logic [CMD_W-1:0] grant_code_q,
    output logic [DATA_W-1:0] grant_data_q,
    output logic wr_refused_q,
    output logic comm_err_q,
    output logic rd_ack_q,
    output logic [15:0] rd_data_q,
    output logic [15:0] extended_command_lock_q,
    output logic permanent_lock_q,
    output logic lock_loaded_q
);
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    generate
        if (CMD_W != 8) begin : g_bad_cmd
            $error("pcl_write_lock: command codes must be 8 bits");
        end
        if (DATA_W < 16) begin : g_bad_data
            $error("pcl_write_lock: data must hold the 16-bit lock field");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Standard write-protect decision for a command other than itself
    function automatic logic std_wp_allows(input logic [7:0] code, input logic [7:0] level);
        case (level)
            `PCL_WP_ALL: std_wp_allows = 1'b0;
            `PCL_WP_OP_ONLY: std_wp_allows = (code == `PCL_CMD_OPERATION);
            `PCL_WP_OP_ONOFF_OUTPUT_SETPOINT_GROUP_LOCK: begin
                std_wp_allows = (code == `PCL_CMD_OPERATION) ||
                                (code == `PCL_CMD_ON_OFF_CONFIG) ||
                                (code == `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_COMMAND);
            end
            default: std_wp_allows = 1'b1;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Command classification
    // ----------------------------------------------------------------
    pcl_cls_e wr_cls;
    pcl_bit_t wr_bit;

    pcl_cmd_classify u_classify (
        .code(wr_code[7:0]),
        .cls(wr_cls),
        .grp_bit(wr_bit)
    );

    // ----------------------------------------------------------------
    // Write decision
    // ----------------------------------------------------------------
    logic self_locked;
    logic write_ok;

    always_comb begin
        self_locked = extended_command_lock_q[`PCL_BIT_SELF] || permanent_lock_q;
        case (wr_cls)
            PCL_CLS_STDWP: begin
                write_ok = !extended_command_lock_q[`PCL_BIT_STDWP];
            end
            PCL_CLS_EXT: begin
                write_ok = !self_locked && !key_locked;
            end
            PCL_CLS_KEY: begin
                write_ok = !self_locked;
            end
            PCL_CLS_GROUP: begin
                // One locks outright, zero defers to write-protect
                write_ok = !extended_command_lock_q[wr_bit] &&
                           std_wp_allows(wr_code[7:0], std_wp_level);
            end
            default: begin
                write_ok = std_wp_allows(wr_code[7:0], std_wp_level);
            end
        endcase
        // Nothing is trusted until the stored lock field has arrived
        if (!lock_loaded_q) begin
            write_ok = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Lock field and write answer
    // ----------------------------------------------------------------
    logic [15:0] lock_d;
    logic perm_d;
    logic loaded_d;
    logic grant_d;
    logic refuse_d;
    logic [CMD_W-1:0] gcode_d;
    logic [DATA_W-1:0] gdata_d;

    always_comb begin
        lock_d = extended_command_lock_q;
        perm_d = permanent_lock_q;
        loaded_d = lock_loaded_q;
        grant_d = 1'b0;
        refuse_d = 1'b0;
        gcode_d = grant_code_q;
        gdata_d = grant_data_q;
        if (wr_valid) begin
            grant_d = write_ok;
            refuse_d = !write_ok;
            if (write_ok) begin
                gcode_d = wr_code;
                gdata_d = wr_data;
                if (wr_cls == PCL_CLS_EXT) begin
                    lock_d = wr_data[15:0];
                end
            end
        end
        // Power-up value comes from the store, overriding any host write
        if (nvm_load) begin
            lock_d = nvm_value;
            loaded_d = 1'b1;
            if (nvm_value[`PCL_BIT_SELF]) begin
                perm_d = 1'b1;
            end
        end
        // A stored self-lock is undone only by reset, never by a later load
        if (nvm_store && extended_command_lock_q[`PCL_BIT_SELF]) begin
            perm_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            extended_command_lock_q <= `PCL_LOCK_RST;
            permanent_lock_q <= 1'b0;
            lock_loaded_q <= 1'b0;
            wr_grant_q <= 1'b0;
            wr_refused_q <= 1'b0;
            comm_err_q <= 1'b0;
            grant_code_q <= '0;
            grant_data_q <= '0;
        end else begin
            extended_command_lock_q <= lock_d;
            permanent_lock_q <= perm_d;
            lock_loaded_q <= loaded_d;
            wr_grant_q <= grant_d;
            wr_refused_q <= refuse_d;
            comm_err_q <= refuse_d;
            grant_code_q <= gcode_d;
            grant_data_q <= gdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Reads are never refused; only the lock field is answered here
    logic rd_ack_d;
    logic [15:0] rd_data_d;

    always_comb begin
        rd_ack_d = 1'b0;
        rd_data_d = rd_data_q;
        if (rd_valid && rd_code == `PCL_CMD_EXT_LOCK) begin
            rd_ack_d = 1'b1;
            rd_data_d = extended_command_lock_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_ack_q <= 1'b0;
            rd_data_q <= 16'h0000;
        end else begin
            rd_ack_q <= rd_ack_d;
            rd_data_q <= rd_data_d;
        end
    end
endmodule

//--- common/pcl_cfg.svh
/*
 * Constants for the command write-lock checker: lock field positions,
 * command codes, standard write-protect levels and reset values.
 * Assumes command codes are 8 bits and the lock field is 16 bits wide.
 */
`ifndef PCL_CFG_SVH
`define PCL_CFG_SVH

// ----------------------------------------------------------------
// Lock field bit positions
// ----------------------------------------------------------------
`define PCL_BIT_SELF 15
`define PCL_BIT_STDWP 14
`define PCL_BIT_TRIM 13
`define PCL_BIT_VSET 12
`define PCL_BIT_VLIM 11
`define PCL_BIT_WARN 10
`define PCL_BIT_ITF 9
`define PCL_BIT_MARGIN 8
`define PCL_BIT_OPER 7
`define PCL_BIT_CFG 6
`define PCL_BIT_VIN 5
`define PCL_BIT_SEQ 4
`define PCL_BIT_IDENT 3
`define PCL_LOCK_RST 16'h0000

// ----------------------------------------------------------------
// Standard command codes
// ----------------------------------------------------------------
`define PCL_CMD_OPERATION 8'h01
`define PCL_CMD_ON_OFF_CONFIG 8'h02
`define PCL_CMD_WRITE_PROTECT 8'h10
`define PCL_CMD_SMBALERT_MASK 8'h1B
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MODE 8'h20
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_COMMAND 8'h21
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_TRIM 8'h22
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MAX 8'h24
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MARGIN_HIGH 8'h25
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MARGIN_LOW 8'h26
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_TRANSITION_RATE 8'h27
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_SCALE_LOOP 8'h29
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MIN 8'h2B
`define PCL_CMD_FREQUENCY_SWITCH 8'h33
`define PCL_CMD_VIN_ON 8'h35
`define PCL_CMD_VIN_OFF 8'h36
`define PCL_CMD_INTERLEAVE 8'h37
`define PCL_CMD_IOUT_CAL_GAIN 8'h38
`define PCL_CMD_IOUT_CAL_OFFSET 8'h39
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_OV_FAULT_LIMIT 8'h40
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_OV_FAULT_RESPONSE 8'h41
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_UV_FAULT_LIMIT 8'h44
`define PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_UV_FAULT_RESPONSE 8'h45
`define PCL_CMD_IOUT_OC_FAULT_LIMIT 8'h46
`define PCL_CMD_IOUT_OC_FAULT_RESPONSE 8'h47
`define PCL_CMD_IOUT_OC_WARN_LIMIT 8'h4A
`define PCL_CMD_OT_FAULT_LIMIT 8'h4F
`define PCL_CMD_OT_FAULT_RESPONSE 8'h50
`define PCL_CMD_OT_WARN_LIMIT 8'h51
`define PCL_CMD_VIN_OV_FAULT_LIMIT 8'h55
`define PCL_CMD_VIN_OV_FAULT_RESPONSE 8'h56
`define PCL_CMD_VIN_OV_WARN_LIMIT 8'h57
`define PCL_CMD_VIN_UV_WARN_LIMIT 8'h58
`define PCL_CMD_TON_DELAY 8'h60
`define PCL_CMD_TON_RISE 8'h61
`define PCL_CMD_TON_MAX_FAULT_LIMIT 8'h62
`define PCL_CMD_TON_MAX_FAULT_RESPONSE 8'h63
`define PCL_CMD_TOFF_DELAY 8'h64
`define PCL_CMD_TOFF_FALL 8'h65
`define PCL_CMD_MFR_ID 8'h99
`define PCL_CMD_MFR_MODEL 8'h9A
`define PCL_CMD_MFR_REVISION 8'h9B
`define PCL_CMD_MFR_SERIAL 8'h9E

// ----------------------------------------------------------------
// Maker-specific command codes
// ----------------------------------------------------------------
`define PCL_CMD_CFG_FIRST 8'hD0
`define PCL_CMD_CFG_LAST 8'hD7
`define PCL_CMD_SIMULATE_FAULTS 8'hD8
`define PCL_CMD_EXT_LOCK 8'hD9
`define PCL_CMD_UNLOCK_KEY 8'hDA

// ----------------------------------------------------------------
// Standard write-protect levels
// ----------------------------------------------------------------
`define PCL_WP_ALL 8'h80
`define PCL_WP_OP_ONLY 8'h40
`define PCL_WP_OP_ONOFF_OUTPUT_SETPOINT_GROUP_LOCK 8'h20

`endif

//--- common/pcl_pkg.sv
/*
 * Types shared by the command write-lock checker.
 * Assumes pcl_cfg.svh supplies the numeric constants.
 */
package pcl_pkg;
    typedef enum logic [2:0] {
        PCL_CLS_FREE = 3'h0,
        PCL_CLS_GROUP = 3'h1,
        PCL_CLS_STDWP = 3'h3,
        PCL_CLS_EXT = 3'h2,
        PCL_CLS_KEY = 3'h6
    } pcl_cls_e;
    typedef logic [15:0] pcl_lock_t;
    typedef logic [3:0] pcl_bit_t;
endpackage

//--- design/pcl_cmd_classify.sv
/*
 * Command classifier: maps a command code to its protection class and,
 * for grouped commands, to the lock field bit that governs it.
 * Assumes a purely combinational use from the same clock domain.
 */
`timescale 1ns/1ns
`include "pcl_cfg.svh"
module pcl_cmd_classify
    import pcl_pkg::*;
(
    input wire logic [7:0] code,
    output pcl_cls_e cls,
    output pcl_bit_t grp_bit
);
    function automatic pcl_bit_t group_of(input logic [7:0] c, output logic hit);
        hit = 1'b1;
        group_of = 4'h0;
        case (c)
            `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_TRIM, `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_SCALE_LOOP,
            `PCL_CMD_IOUT_CAL_GAIN, `PCL_CMD_IOUT_CAL_OFFSET: group_of = `PCL_BIT_TRIM;
            `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MODE, `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_COMMAND: group_of = `PCL_BIT_VSET;
            `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MAX, `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MIN, `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_OV_FAULT_LIMIT,
            `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_OV_FAULT_RESPONSE, `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_UV_FAULT_LIMIT,
            `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_UV_FAULT_RESPONSE: group_of = `PCL_BIT_VLIM;
            `PCL_CMD_IOUT_OC_WARN_LIMIT, `PCL_CMD_OT_WARN_LIMIT,
            `PCL_CMD_SMBALERT_MASK: group_of = `PCL_BIT_WARN;
            `PCL_CMD_OT_FAULT_LIMIT, `PCL_CMD_OT_FAULT_RESPONSE, `PCL_CMD_SIMULATE_FAULTS,
            `PCL_CMD_IOUT_OC_FAULT_LIMIT,
            `PCL_CMD_IOUT_OC_FAULT_RESPONSE: group_of = `PCL_BIT_ITF;
            `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MARGIN_HIGH, `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_MARGIN_LOW,
            `PCL_CMD_OUTPUT_SETPOINT_GROUP_LOCK_TRANSITION_RATE: group_of = `PCL_BIT_MARGIN;
            `PCL_CMD_OPERATION: group_of = `PCL_BIT_OPER;
            `PCL_CMD_FREQUENCY_SWITCH, `PCL_CMD_INTERLEAVE: group_of = `PCL_BIT_CFG;
            `PCL_CMD_VIN_UV_WARN_LIMIT, `PCL_CMD_VIN_OV_FAULT_LIMIT, `PCL_CMD_VIN_OV_WARN_LIMIT,
            `PCL_CMD_VIN_OV_FAULT_RESPONSE: group_of = `PCL_BIT_VIN;
            `PCL_CMD_TON_DELAY, `PCL_CMD_TON_RISE, `PCL_CMD_TON_MAX_FAULT_LIMIT,
            `PCL_CMD_TON_MAX_FAULT_RESPONSE, `PCL_CMD_TOFF_DELAY, `PCL_CMD_TOFF_FALL,
            `PCL_CMD_ON_OFF_CONFIG, `PCL_CMD_VIN_ON,
            `PCL_CMD_VIN_OFF: group_of = `PCL_BIT_SEQ;
            `PCL_CMD_MFR_ID, `PCL_CMD_MFR_MODEL, `PCL_CMD_MFR_REVISION,
            `PCL_CMD_MFR_SERIAL: group_of = `PCL_BIT_IDENT;
            default: begin
                // Maker-specific configuration commands sit in one code range
                if (c >= `PCL_CMD_CFG_FIRST && c <= `PCL_CMD_CFG_LAST) begin
                    group_of = `PCL_BIT_CFG;
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    endfunction

    logic hit;

    always_comb begin
        hit = 1'b0;
        grp_bit = group_of(code, hit);
        if (code == `PCL_CMD_WRITE_PROTECT) begin
            cls = PCL_CLS_STDWP;
        end else if (code == `PCL_CMD_EXT_LOCK) begin
            cls = PCL_CLS_EXT;
        end else if (code == `PCL_CMD_UNLOCK_KEY) begin
            cls = PCL_CLS_KEY;
        end else if (hit) begin
            cls = PCL_CLS_GROUP;
        end else begin
            cls = PCL_CLS_FREE;
        end
    end
endmodule

//--- tb/pcl_write_lock_props.sv
/* Port-level checker for the command write-lock block.
   Assumes it is bound into pcl_write_lock and samples on ref_clk. */
`timescale 1ns/1ns
`include "pcl_cfg.svh"
module pcl_write_lock_props #(
    parameter int CMD_W = 8,
    parameter int DATA_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_valid,
    input wire logic [CMD_W-1:0] wr_code,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_valid,
    input wire logic [CMD_W-1:0] rd_code,
    input wire logic [7:0] std_wp_level,
    input wire logic key_locked,
    input wire logic nvm_load,
    input wire logic [15:0] nvm_value,
    input wire logic nvm_store,
    input wire logic wr_grant_q,
    input wire logic [CMD_W-1:0] grant_code_q,
    input wire logic [DATA_W-1:0] grant_data_q,
    input wire logic wr_refused_q,
    input wire logic comm_err_q,
    input wire logic rd_ack_q,
    input wire logic [15:0] rd_data_q,
    input wire logic [15:0] extended_command_lock_q,
    input wire logic permanent_lock_q,
    input wire logic lock_loaded_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire [15:0] lk = extended_command_lock_q;

    wr_answer_a: assert property (wr_valid |=> wr_grant_q != wr_refused_q)
        else $error("write not answered exactly once");
    err_pair_a: assert property (comm_err_q == wr_refused_q)
        else $error("comm error not paired with refusal");
    refuse_hold_a: assert property (wr_refused_q && !$past(nvm_load) |-> $stable(lk))
        else $error("refused write changed lock field");
    op_lock_a: assert property (wr_valid && wr_code == `PCL_CMD_OPERATION
        && lk[`PCL_BIT_OPER] |=> wr_refused_q)
        else $error("locked operation write granted");
    ident_lock_a: assert property (wr_valid && wr_code == `PCL_CMD_MFR_SERIAL
        && lk[`PCL_BIT_IDENT] |=> wr_refused_q)
        else $error("locked ident write granted");
    wp_free_a: assert property (wr_valid && wr_code == `PCL_CMD_WRITE_PROTECT && !nvm_load
        && lock_loaded_q && !lk[`PCL_BIT_STDWP] |=> wr_grant_q)
        else $error("write-protect command refused");
    self_lock_a: assert property (wr_valid && wr_code == `PCL_CMD_EXT_LOCK
        && (lk[`PCL_BIT_SELF] || permanent_lock_q || key_locked) |=> wr_refused_q)
        else $error("self-locked field write granted");
    perm_keep_a: assert property (permanent_lock_q |=> permanent_lock_q)
        else $error("permanent lock cleared");
    nvm_load_a: assert property (nvm_load |=> lk == $past(nvm_value) && lock_loaded_q)
        else $error("stored value not restored");
    rd_answer_a: assert property (rd_valid && rd_code == `PCL_CMD_EXT_LOCK && !wr_valid
        && !nvm_load |=> rd_ack_q && rd_data_q == $past(lk))
        else $error("lock field read wrong");
    grant_echo_a: assert property (wr_grant_q |-> grant_code_q == $past(wr_code)
        && grant_data_q == $past(wr_data))
        else $error("granted write not passed on");

    cover property (wr_valid ##1 wr_refused_q);
    cover property (wr_valid ##1 wr_grant_q);
    cover property (rd_ack_q);
    cover property ($rose(permanent_lock_q));
endmodule
bind pcl_write_lock pcl_write_lock_props #(.CMD_W(CMD_W), .DATA_W(DATA_W)) i_props (.*);

//--- tb/pcl_host_model.sv
/* Host model: issues command writes and lock-field reads, one a cycle.
   Assumes the bench hands it the expected outcome of every request. */
`timescale 1ns/1ns
`include "pcl_cfg.svh"
module pcl_host_model (
    input wire logic ref_clk,
    output logic wr_valid,
    output logic [7:0] wr_code,
    output logic [15:0] wr_data,
    output logic rd_valid,
    output logic [7:0] rd_code
);
    logic [8:0] wq[$];
    logic [15:0] rq[$];
    initial begin
        wr_valid = 1'b0;
        rd_valid = 1'b0;
        wr_code = 8'h00;
        wr_data = 16'h0000;
        rd_code = 8'h00;
    end
    // Valid stays up between calls so back-to-back writes need no gap
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ok);
        @(posedge ref_clk);
        wr_valid <= 1'b1;
        rd_valid <= 1'b0;
        wr_code <= c;
        wr_data <= d;
        wq.push_back({ok, c});
    endtask
    task automatic rd(input logic [15:0] e);
        @(posedge ref_clk);
        rd_valid <= 1'b1;
        wr_valid <= 1'b0;
        rd_code <= `PCL_CMD_EXT_LOCK;
        rq.push_back(e);
    endtask
    // Released write lines show the inverse so stale values never look valid; rd_code keeps its value
    task automatic idle();
        @(posedge ref_clk);
        wr_valid <= 1'b0;
        rd_valid <= 1'b0;
        wr_code <= ~wr_code;
        wr_data <= ~wr_data;
    endtask
endmodule

//--- tb/pmbus_command_write_lock_bench.sv
/* Self-checking bench for the command write-lock block.
   Assumes a 10 MHz ref_clk and a synchronous active-high reset. */
`timescale 1ns/1ns
module pmbus_command_write_lock_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wr_valid, rd_valid, wr_grant_q, wr_refused_q, rd_ack_q, perm_q;
    logic key_locked = 1'b0, nvm_load = 1'b0, nvm_store = 1'b0;
    logic [7:0] wr_code, rd_code, grant_code_q, std_wp_level = 8'h00;
    logic [15:0] wr_data, rd_data_q, lock_q, nvm_value = 16'h0000, lk = 16'h0000, d;
    logic perm = 1'b0, loaded = 1'b0;
    logic [7:0] wps [4] = '{8'h00, 8'h80, 8'h40, 8'h20};
    logic [7:0] cmds [34] = '{8'h01, 8'h02, 8'h03, 8'h1B, 8'h20, 8'h21, 8'h22, 8'h24,
        8'h25, 8'h27, 8'h29, 8'h33, 8'h35, 8'h36, 8'h37, 8'h38, 8'h40, 8'h45, 8'h46,
        8'h4A, 8'h4F, 8'h50, 8'h51, 8'h55, 8'h57, 8'h58, 8'h60, 8'h65, 8'h99, 8'h9A,
        8'h9E, 8'hD0, 8'hD7, 8'hD8};
    int num_errors = 0, samples_checked = 0, seed = 10096;

    pcl_host_model i_host (.ref_clk(ref_clk), .wr_valid(wr_valid), .wr_code(wr_code),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_code(rd_code));
    pcl_write_lock i_dut (.ref_clk(ref_clk), .rst(rst), .wr_valid(wr_valid),
        .wr_code(wr_code), .wr_data(wr_data), .rd_valid(rd_valid), .rd_code(rd_code),
        .std_wp_level(std_wp_level), .key_locked(key_locked), .nvm_load(nvm_load),
        .nvm_value(nvm_value), .nvm_store(nvm_store), .wr_grant_q(wr_grant_q),
        .grant_code_q(grant_code_q), .grant_data_q(), .wr_refused_q(wr_refused_q),
        .comm_err_q(), .rd_ack_q(rd_ack_q), .rd_data_q(rd_data_q),
        .extended_command_lock_q(lock_q), .permanent_lock_q(perm_q), .lock_loaded_q());

    initial forever #50 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Reference model of the lock decision
    // ------------------------------------------------------------
    function automatic int grp(input logic [7:0] c);
        case (c)
            8'h01: grp = 7;
            8'h02, 8'h35, 8'h36, 8'h60, 8'h65: grp = 4;
            8'h1B, 8'h4A, 8'h51: grp = 10;
            8'h20, 8'h21: grp = 12;
            8'h22, 8'h29, 8'h38: grp = 13;
            8'h24, 8'h40, 8'h45: grp = 11;
            8'h25, 8'h27: grp = 8;
            8'h33, 8'h37, 8'hD0, 8'hD7: grp = 6;
            8'h46, 8'h4F, 8'h50, 8'hD8: grp = 9;
            8'h55, 8'h57, 8'h58: grp = 5;
            8'h99, 8'h9A, 8'h9E: grp = 3;
            default: grp = -1;
        endcase
    endfunction
    function automatic logic exp_ok(input logic [7:0] c);
        int g;
        g = grp(c);
        if (!loaded) return 1'b0;
        if (c == 8'h10) return !lk[14];
        if (c == 8'hD9) return !(lk[15] || perm || key_locked);
        if (c == 8'hDA) return !(lk[15] || perm);
        if (g >= 0 && lk[g]) return 1'b0;
        case (std_wp_level)
            8'h80: return 1'b0;
            8'h40: return c == 8'h01;
            8'h20: return c == 8'h01 || c == 8'h02 || c == 8'h21;
            default: return 1'b1;
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_wr(input logic [7:0] c, input logic [15:0] v);
        logic ok;
        ok = exp_ok(c);
        if (ok && c == 8'hD9) lk = v;
        i_host.wr(c, v, ok);
    endtask
    // Two idle edges so the new levels have landed before the next decision
    task automatic env(input logic [7:0] w, input logic k);
        i_host.idle();
        std_wp_level <= w;
        key_locked <= k;
        i_host.idle();
    endtask
    task automatic nv(input logic ld, input logic st, input logic [15:0] v);
        i_host.idle();
        nvm_load <= ld;
        nvm_store <= st;
        nvm_value <= v;
        i_host.idle();
        nvm_load <= 1'b0;
        nvm_store <= 1'b0;
        if (st) perm = perm | lk[15];
        if (ld) {loaded, lk, perm} = {1'b1, v, perm | v[15]};
    endtask

    always @(negedge ref_clk) begin
        logic [8:0] n;
        if ((wr_grant_q | wr_refused_q) === 1'b1) begin
            n = (i_host.wq.size() > 0) ? i_host.wq.pop_front() : 9'h1FF;
            check({15'h0000, wr_grant_q}, {15'h0000, n[8]});
            if (wr_grant_q) check({8'h00, grant_code_q}, {8'h00, n[7:0]});
        end
        if (rd_ack_q === 1'b1) check(rd_data_q, i_host.rq.pop_front());
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        do_wr(8'h01, 16'h1234);
        i_host.rd(16'h0000);
        nv(1'b1, 1'b0, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            env(wps[i % 4], 1'b0);
            d = $random(seed);
            d[15] = 1'b0;
            do_wr(8'hD9, d);
            i_host.rd(lk);
            foreach (cmds[j]) do_wr(cmds[j], $random(seed));
            do_wr(8'h10, $random(seed));
            do_wr(8'hDA, $random(seed));
        end
        env(8'h00, 1'b1);
        do_wr(8'hD9, 16'h0000);
        env(8'h00, 1'b0);
        do_wr(8'hD9, 16'h8000);
        do_wr(8'hD9, 16'h0000);
        do_wr(8'hDA, 16'h5A5A);
        nv(1'b0, 1'b1, 16'h0000);
        nv(1'b1, 1'b0, 16'h0000);
        do_wr(8'hD9, 16'h0000);
        i_host.rd(lk);
        i_host.idle();
        for (int k = 0; k < 10 && i_host.wq.size() + i_host.rq.size() > 0; k++)
            @(posedge ref_clk);
        check(16'(i_host.wq.size() + i_host.rq.size()), 16'h0000);
        check(lock_q, lk);
        check({15'h0000, perm_q}, 16'h0001);
        wrap_up();
    end
endmodule
